/* File: autoneg_register_set.sv */
// Purpose: copper autonegotiation register set, indices 4 to 9, on AHB-Lite
// Assumes: line-side inputs come from the arbitration logic on hclk
// Notes: interrupt status and mask sit at indices 0x10 and 0x11
`timescale 1ns/100ps
`default_nettype none
`include "autoneg_regs_cfg.svh"

module autoneg_register_set
#(
  // width of one register word
  parameter int REG_W = 16,
  // sticky events behind the expansion latches and the interrupt
  parameter int EVT_N = `IRQ_W
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interrupt
  output logic irq,
  // from the arbitration logic
  input wire logic [15:0] lp_base_page,
  input wire logic lp_base_valid,
  input wire logic [15:0] lp_next_page,
  input wire logic lp_next_valid,
  input wire logic lp_an_able,
  input wire logic lp_np_able,
  input wire logic pd_fault_evt,
  input wire logic prev_link_codeword_toggle,
  // to the arbitration logic
  output logic [15:0] adv_page,
  output logic [15:0] np_tx_page,
  output logic np_tx_load,
  output logic [2:0] test_mode,
  output logic ms_force_master,
  output logic ms_force_slave,
  output logic port_multi,
  output logic adv_1000_fdx,
  output logic adv_1000_hdx
);

  autoneg_regs_pkg::regs_state_t s_r;
  autoneg_regs_pkg::regs_state_t s_nxt;
  logic rd_en;
  logic [`REG_IDX_W-1:0] rd_idx;
  logic wr_en;
  logic [`REG_IDX_W-1:0] wr_idx;
  logic [15:0] wd;
  logic [15:0] exp_view;
  logic page_evt;
  logic rd_exp;
  logic irq_clr_hit;
  logic [`IRQ_W-1:0] irq_set;
  logic [EVT_N-1:0] irq_nxt;
  logic [EVT_N-1:0] exp_old;
  logic [EVT_N-1:0] exp_nxt;

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  ahb_lite_reg_port u_port
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_en(rd_en),
    .rd_idx(rd_idx),
    .wr_en(wr_en),
    .wr_idx(wr_idx)
  );

  // ----------------------------------------------------------------
  // read views
  // ----------------------------------------------------------------
  assign wd = hwdata[15:0];
  assign page_evt = lp_base_valid | lp_next_valid;
  assign rd_exp = rd_en & (rd_idx == `AN_EXP_IDX);
  assign irq_set = {pd_fault_evt, page_evt};
  assign irq_clr_hit = wr_en & (wr_idx == `IRQ_STATUS_IDX);
  assign exp_old = {s_r.pd_fault, s_r.page_rx};

  // latched bits show the settled value; a same-cycle event waits
  assign exp_view = {11'h000,
                     s_r.pd_fault,
                     lp_np_able,
                     1'b1,
                     s_r.page_rx,
                     lp_an_able};

  // ----------------------------------------------------------------
  // sticky events
  // ----------------------------------------------------------------
  // one bit per event: expansion latch and interrupt status alike
  for (genvar i = 0; i < EVT_N; i++)
  begin : g_evt
    // set wins over a read or write-one clear in the same cycle
    assign exp_nxt[i] = (exp_old[i] & ~rd_exp) | irq_set[i];
    assign irq_nxt[i] = (s_r.irq_status[i] & ~(irq_clr_hit & wd[i])) | irq_set[i];
  end

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the packed state record and the read views are sized for these only
  if (REG_W != 16)
  begin : g_bad_width
    $error("register width must be 16");
  end
  if (EVT_N != `IRQ_W)
  begin : g_bad_events
    $error("event count must match the interrupt layout");
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.np_load = 1'b0;
    // data-phase writes; read-only bits masked off
    if (wr_en)
    begin
      unique case (wr_idx)
        `AN_ADV_IDX:
        begin
          s_nxt.adv = wd & `AN_ADV_WMASK;
        end
        `NP_TX_IDX:
        begin
          s_nxt.np_tx = wd & `NP_TX_WMASK;
          s_nxt.np_load = 1'b1;
        end
        `GIG_CTRL_IDX:
        begin
          s_nxt.gig = wd;
        end
        `IRQ_STATUS_IDX:
        begin
          s_nxt.irq_status = irq_nxt;
        end
        `IRQ_MASK_IDX:
        begin
          s_nxt.irq_mask = wd[`IRQ_W-1:0];
        end
        default:
        begin
          s_nxt.adv = s_r.adv;
        end
      endcase
    end
    // partner pages land only from the line side
    if (lp_base_valid)
    begin
      s_nxt.lp_base = lp_base_page;
    end
    if (lp_next_valid)
    begin
      s_nxt.lp_np = lp_next_page;
    end
    // set wins over the clear of a read or a write-one
    s_nxt.pd_fault = exp_nxt[`IRQ_PD_FAULT_BIT];
    s_nxt.page_rx = exp_nxt[`IRQ_PAGE_RX_BIT];
    s_nxt.irq_status = irq_nxt;
    // read data forwarded from the post-write values; interrupt status reads the pre-write value
    if (rd_en)
    begin
      unique case (rd_idx)
        `AN_ADV_IDX:
        begin
          s_nxt.hrdata = {16'h0000, s_nxt.adv};
        end
        `LP_BASE_IDX:
        begin
          s_nxt.hrdata = {16'h0000, s_r.lp_base};
        end
        `AN_EXP_IDX:
        begin
          s_nxt.hrdata = {16'h0000, exp_view};
        end
        `NP_TX_IDX:
        begin
          s_nxt.hrdata = {16'h0000, s_nxt.np_tx};
          // toggle is never stored, so a write cannot disturb it
          s_nxt.hrdata[`NP_TOGGLE_BIT] = ~prev_link_codeword_toggle;
        end
        `LP_NP_IDX:
        begin
          s_nxt.hrdata = {16'h0000, s_r.lp_np};
        end
        `GIG_CTRL_IDX:
        begin
          s_nxt.hrdata = {16'h0000, s_nxt.gig};
        end
        `IRQ_STATUS_IDX:
        begin
          s_nxt.hrdata = {30'h00000000, s_r.irq_status};
        end
        `IRQ_MASK_IDX:
        begin
          s_nxt.hrdata = {30'h00000000, s_nxt.irq_mask};
        end
        default:
        begin
          s_nxt.hrdata = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r <= '0;
      s_r.adv <= `AN_ADV_RST;
      s_r.np_tx <= `NP_TX_RST;
      s_r.gig <= `GIG_CTRL_RST;
      s_r.lp_base <= `LP_RST;
      s_r.lp_np <= `LP_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata = s_r.hrdata;
  assign irq = |(s_r.irq_status & s_r.irq_mask);
  assign adv_page = s_r.adv;
  assign np_tx_load = s_r.np_load;

  always_comb
  begin
    np_tx_page = s_r.np_tx;
    np_tx_page[`NP_TOGGLE_BIT] = ~prev_link_codeword_toggle;
  end

  // no interlock with media sensing; software owns that ordering
  assign test_mode = s_r.gig[`GIG_TEST_HI:`GIG_TEST_LO];
  assign ms_force_master = s_r.gig[`GIG_MS_MANUAL_BIT]
                         & s_r.gig[`GIG_MS_VALUE_BIT];
  assign ms_force_slave = s_r.gig[`GIG_MS_MANUAL_BIT]
                        & ~s_r.gig[`GIG_MS_VALUE_BIT];
  assign port_multi = s_r.gig[`GIG_PORT_MULTI_BIT];
  assign adv_1000_fdx = s_r.gig[`GIG_1000_FDX_BIT];
  assign adv_1000_hdx = s_r.gig[`GIG_1000_HDX_BIT];

endmodule // autoneg_register_set
`default_nettype wire

/* File: autoneg_regs_cfg.svh */
// Purpose: offsets, field positions, reset values of the autoneg register set
// Assumes: 32-bit AHB-Lite words, byte address = 4 * register index
// Notes: definitions only
`ifndef AUTONEG_REGS_CFG_SVH
`define AUTONEG_REGS_CFG_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define REG_IDX_W 6
`define AN_ADV_IDX 6'h04
`define LP_BASE_IDX 6'h05
`define AN_EXP_IDX 6'h06
`define NP_TX_IDX 6'h07
`define LP_NP_IDX 6'h08
`define GIG_CTRL_IDX 6'h09
`define IRQ_STATUS_IDX 6'h10
`define IRQ_MASK_IDX 6'h11

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define AN_ADV_RST 16'h01e1
`define AN_ADV_WMASK 16'hbfff
`define NP_TX_RST 16'h2000
`define NP_TX_WMASK 16'hb7ff
`define GIG_CTRL_RST 16'h0700
`define LP_RST 16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NP_TOGGLE_BIT 11
`define GIG_TEST_HI 15
`define GIG_TEST_LO 13
`define GIG_MS_MANUAL_BIT 12
`define GIG_MS_VALUE_BIT 11
`define GIG_PORT_MULTI_BIT 10
`define GIG_1000_FDX_BIT 9
`define GIG_1000_HDX_BIT 8
`define IRQ_PAGE_RX_BIT 0
`define IRQ_PD_FAULT_BIT 1
`define IRQ_W 2

`endif

/* File: autoneg_regs_pkg.sv */
// Purpose: state types of the autoneg register set and its bus port
// Assumes: widths from autoneg_regs_cfg.svh
// Notes: types only
`default_nettype none
package autoneg_regs_pkg;

  // ----------------------------------------------------------------
  // transmitter test selections
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TEST_NORMAL = 3'h0,
    TEST_WAVEFORM = 3'h1,
    TEST_JITTER_MASTER = 3'h2,
    TEST_JITTER_SLAVE = 3'h3,
    TEST_DISTORTION = 3'h4
  } test_mode_t;

  // ----------------------------------------------------------------
  // state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic [5:0] wr_idx;
  } port_state_t;

  typedef struct packed {
    logic [15:0] adv;
    logic [15:0] lp_base;
    logic [15:0] np_tx;
    logic [15:0] lp_np;
    logic [15:0] gig;
    logic pd_fault;
    logic page_rx;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic np_load;
    logic [31:0] hrdata;
  } regs_state_t;

endpackage
`default_nettype wire

/* File: ahb_lite_reg_port.sv */
// Purpose: AHB-Lite slave front end, zero wait states, always OKAY
// Assumes: single word transfers; one slave on the bus
// Notes: read strobe in address phase, write strobe in data phase
`timescale 1ns/100ps
`default_nettype none
`include "autoneg_regs_cfg.svh"

module ahb_lite_reg_port
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  // register side
  output logic rd_en,
  output logic [`REG_IDX_W-1:0] rd_idx,
  output logic wr_en,
  output logic [`REG_IDX_W-1:0] wr_idx
);

  autoneg_regs_pkg::port_state_t s_r;
  autoneg_regs_pkg::port_state_t s_nxt;
  logic take;
  logic hit;

  // ----------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------
  // bytes above the register window decode as unmapped
  assign hit = (haddr[31:8] == 24'h000000);
  assign take = hsel & htrans[1] & hready;
  assign rd_en = take & ~hwrite & hit;
  assign rd_idx = haddr[7:2];
  assign wr_en = s_r.wr_pend;
  assign wr_idx = s_r.wr_idx;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb
  begin
    s_nxt = s_r;
    if (hready)
    begin
      s_nxt.wr_pend = take & hwrite & hit;
      s_nxt.wr_idx = haddr[7:2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule // ahb_lite_reg_port
`default_nettype wire

/* File: autoneg_checker_assertions.sv */
// Purpose: port checks of the autoneg register set
// Assumes: hready tied to hreadyout, write data one cycle after address
// Notes: bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module autoneg_checker
(
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  // line side and outputs
  input wire logic irq,
  input wire logic lp_base_valid,
  input wire logic lp_next_valid,
  input wire logic pd_fault_evt,
  input wire logic prev_link_codeword_toggle,
  input wire logic [15:0] adv_page,
  input wire logic [15:0] np_tx_page,
  input wire logic np_tx_load,
  input wire logic [2:0] test_mode,
  input wire logic ms_force_master,
  input wire logic ms_force_slave,
  input wire logic port_multi,
  input wire logic adv_1000_fdx,
  input wire logic adv_1000_hdx
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic wr;
  logic [15:0] wd;
  assign wr = hsel && htrans[1] && hwrite;
  assign wd = hwdata[15:0];
  toggle_inv_a: assert property (np_tx_page[11] == !prev_link_codeword_toggle)
    else $error("toggle bit not inverted");
  adv_wr_a: assert property (wr && haddr == 32'h10 ##1 1'b1 |=>
    adv_page == ($past(wd) & 16'hbfff)) else $error("advert write wrong");
  adv_hold_a: assert property (!$stable(adv_page) |->
    $past(wr && haddr == 32'h10, 2)) else $error("advert changed unasked");
  np_load_a: assert property (wr && haddr == 32'h1c ##1 1'b1 |=> np_tx_load &&
    (np_tx_page & 16'hb7ff) == ($past(wd) & 16'hb7ff)) else $error("next page write wrong");
  gig_wr_a: assert property (wr && haddr == 32'h24 ##1 1'b1 |=>
    test_mode == $past(wd[15:13]) && {port_multi, adv_1000_fdx, adv_1000_hdx} ==
    $past(wd[10:8])) else $error("gigabit control wrong");
  ms_clr_a: assert property (wr && haddr == 32'h24 ##1 !wd[12] |=>
    !ms_force_master && !ms_force_slave) else $error("force without manual");
  ms_set_a: assert property (wr && haddr == 32'h24 ##1 wd[12] |=>
    ms_force_master == $past(wd[11]) && ms_force_slave == !$past(wd[11]))
    else $error("manual force wrong");
  irq_cause_a: assert property ($rose(irq) |->
    $past(lp_base_valid || lp_next_valid || pd_fault_evt) || $past(wr, 2))
    else $error("interrupt without cause");
  cover property (np_tx_load);
  cover property ($rose(irq));
  cover property (test_mode == 3'h4);
endmodule // autoneg_checker
bind autoneg_register_set autoneg_checker autoneg_checker_i
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .irq, .lp_base_valid,
  .lp_next_valid, .pd_fault_evt, .prev_link_codeword_toggle, .adv_page, .np_tx_page,
  .np_tx_load, .test_mode, .ms_force_master, .ms_force_slave, .port_multi,
  .adv_1000_fdx, .adv_1000_hdx
);
`default_nettype wire

/* File: partner_model.sv */
// Purpose: far end as seen through the arbitration outputs
// Assumes: pulses one hclk wide
// Notes: page lines show the inverse once released, never a stale copy
`timescale 1ns/100ps
`default_nettype none
module partner_model
(
  // clock
  input wire logic hclk,
  // received pages
  output logic [15:0] lp_base_page,
  output logic lp_base_valid,
  output logic [15:0] lp_next_page,
  output logic lp_next_valid,
  // abilities and events
  output logic lp_an_able,
  output logic lp_np_able,
  output logic pd_fault_evt,
  output logic prev_link_codeword_toggle
);
  initial
  begin
    {lp_base_page, lp_next_page} = 32'hffff_ffff;
    {lp_base_valid, lp_next_valid, pd_fault_evt} = 3'h0;
    {lp_an_able, lp_np_able, prev_link_codeword_toggle} = 3'h0;
  end
  task automatic levels(input logic an, input logic np, input logic tog);
    @(posedge hclk);
    lp_an_able <= an;
    lp_np_able <= np;
    prev_link_codeword_toggle <= tog;
    #1;
  endtask
  task automatic send(input logic nxt, input logic [15:0] pg);
    @(posedge hclk);
    lp_base_page <= nxt ? ~pg : pg;
    lp_next_page <= nxt ? pg : ~pg;
    lp_base_valid <= !nxt;
    lp_next_valid <= nxt;
    @(posedge hclk);
    {lp_base_valid, lp_next_valid} <= 2'h0;
    {lp_base_page, lp_next_page} <= {~pg, ~pg};
    #1;
  endtask
  task automatic fault();
    @(posedge hclk);
    pd_fault_evt <= 1'b1;
    @(posedge hclk);
    pd_fault_evt <= 1'b0;
    #1;
  endtask
endmodule // partner_model
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench of the autoneg register set
// Assumes: zero wait states, hready tied to hreadyout
// Notes: partner_model drives the line side
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, irq, np_tx_load;
  logic [1:0] htrans;
  logic [2:0] hsize, test_mode;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] lp_base_page, lp_next_page, adv_page, np_tx_page;
  logic lp_base_valid, lp_next_valid, lp_an_able, lp_np_able, pd_fault_evt;
  logic prev_link_codeword_toggle, ms_force_master, ms_force_slave;
  logic port_multi, adv_1000_fdx, adv_1000_hdx;
  wire logic hready;
  int num_errors = 0;
  int samples_checked = 0;
  assign hready = hreadyout;
  autoneg_register_set autoneg_register_set_i
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
    .hreadyout, .hresp, .hrdata, .irq, .lp_base_page, .lp_base_valid, .lp_next_page,
    .lp_next_valid, .lp_an_able, .lp_np_able, .pd_fault_evt, .prev_link_codeword_toggle,
    .adv_page, .np_tx_page, .np_tx_load, .test_mode, .ms_force_master, .ms_force_slave,
    .port_multi, .adv_1000_fdx, .adv_1000_hdx
  );
  partner_model partner_model_i
  (
    .hclk, .lp_base_page, .lp_base_valid, .lp_next_page, .lp_next_valid,
    .lp_an_able, .lp_np_able, .pd_fault_evt, .prev_link_codeword_toggle
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // waits are cut short by the watchdog only
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    q = hrdata;
    #1;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic t_reset();
    rd(32'h10, 32'h01e1);
    rd(32'h14, 32'h0);
    rd(32'h18, 32'h4);
    rd(32'h1c, 32'h2800);
    rd(32'h20, 32'h0);
    rd(32'h24, 32'h0700);
    $display("done reset values");
  endtask
  task automatic t_ro();
    logic [31:0] e [6] = '{32'hbfff, 32'h0, 32'h4, 32'hbfff, 32'h0, 32'hffff};
    for (int i = 0; i < 6; i++)
    begin
      wr(32'h10 + 4 * i, 32'hffff_ffff);
      rd(32'h10 + 4 * i, e[i]);
    end
    wr(32'h28, 32'hffff_ffff);
    rd(32'h28, 32'h0);
    rd(32'h110, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    chk({16'h0, adv_page}, 32'hbfff);
    wr(32'h1c, 32'hffff_ffff);
    chk({15'h0, np_tx_load, np_tx_page}, 32'h0001_bfff);
    $display("done read-only bits");
  endtask
  task automatic t_gig();
    for (int m = 0; m < 5; m++)
    begin
      wr(32'h24, {16'h0, 3'(m), 13'h0700}); // media sense is off here
      chk({29'h0, test_mode}, 32'(m));
    end
    wr(32'h24, 32'h0800);
    chk({30'h0, ms_force_master, ms_force_slave}, 32'h0);
    wr(32'h24, 32'h1800);
    chk({30'h0, ms_force_master, ms_force_slave}, 32'h2);
    wr(32'h24, 32'h1200);
    chk({27'h0, ms_force_master, ms_force_slave, port_multi, adv_1000_fdx, adv_1000_hdx},
      32'h0a);
    rd(32'h24, 32'h1200);
    $display("done gigabit control");
  endtask
  task automatic t_page();
    partner_model_i.levels(1'b1, 1'b1, 1'b0);
    partner_model_i.send(1'b0, 16'habcd);
    rd(32'h14, 32'habcd);
    rd(32'h18, 32'h000f);
    rd(32'h18, 32'h000d);
    partner_model_i.send(1'b1, 16'h5a5a);
    partner_model_i.fault();
    rd(32'h20, 32'h5a5a);
    rd(32'h18, 32'h001f);
    rd(32'h18, 32'h000d);
    partner_model_i.levels(1'b0, 1'b0, 1'b1);
    rd(32'h18, 32'h0004);
    rd(32'h1c, 32'hb7ff);
    $display("done partner pages");
  endtask
  task automatic t_irq();
    wr(32'h40, 32'h3);
    partner_model_i.fault();
    chk({31'h0, irq}, 32'h0);
    wr(32'h44, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rd(32'h40, 32'h2);
    wr(32'h40, 32'h2);
    chk({31'h0, irq}, 32'h0);
    partner_model_i.send(1'b1, 16'h0001);
    wr(32'h44, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(32'h44, 32'h1);
    $display("done interrupt");
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial
  begin
    #(50 * 5000);
    num_errors++;
    test_done();
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_ro();
    t_gig();
    t_page();
    t_irq();
    test_done();
  end
endmodule // tb
`default_nettype wire
